// [design/ate_params.svh]
// constants for the accumulator transfer execution block
`ifndef ATE_PARAMS_SVH
`define ATE_PARAMS_SVH

// instruction codes (10-bit words)
`define ATE_OP_LCD1 10'h2a8
`define ATE_OP_LCD2 10'h2a9
`define ATE_OP_LCD3 10'h2aa
`define ATE_OP_DREG 10'h029
`define ATE_OP_EREG 10'h01a
`define ATE_OP_FR0 10'h228

// register byte offsets
`define ATE_ADR_ACC 8'h00
`define ATE_ADR_REGB 8'h04
`define ATE_ADR_INSTR 8'h08
`define ATE_ADR_LCD1 8'h0c
`define ATE_ADR_LCD2 8'h10
`define ATE_ADR_LCD3 8'h14
`define ATE_ADR_DREG 8'h18
`define ATE_ADR_EREG 8'h1c
`define ATE_ADR_FR0 8'h20
`define ATE_ADR_STATUS 8'h24
`define ATE_ADR_COUNT 8'h28

// field positions
`define ATE_E_HI_MSB 7
`define ATE_E_HI_LSB 4
`define ATE_E_LO_MSB 3
`define ATE_D_MSB 2

// reset values
`define ATE_RST_NIBBLE 4'h0
`define ATE_RST_D 3'h0
`define ATE_RST_E 8'h00
`define ATE_RST_WORD 10'h000
`define ATE_RST_COUNT 16'h0000

// ahb encodings
`define ATE_HTRANS_NONSEQ 2'b10
`define ATE_HSIZE_WORD 3'b010

`endif

// [design/ate_pkg.sv]
// types shared by the accumulator transfer execution block
`default_nettype none

package ate_pkg;

  typedef enum logic [2:0] {
    ATE_K_NONE,
    ATE_K_LCD1,
    ATE_K_LCD2,
    ATE_K_LCD3,
    ATE_K_DREG,
    ATE_K_EREG,
    ATE_K_FR0
  } ate_kind_type;

  typedef struct packed {
    logic dataPhase;
    logic write;
    logic [7:0] addr;
  } ate_bus_state_type;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] regB;
    logic [9:0] lastWord;
    logic [3:0] lcdCtrlFirst;
    logic [3:0] lcdCtrlSecond;
    logic [3:0] lcdCtrlThird;
    logic [2:0] dReg;
    logic [7:0] eReg;
    logic [3:0] portStructCtrl0;
    ate_kind_type lastKind;
    logic [15:0] execCount;
  } ate_core_state_type;

endpackage : ate_pkg

`default_nettype wire

// [design/ate_decode.sv]
// instruction decoder for the accumulator transfer group
`default_nettype none
`include "ate_params.svh"

module ate_decode
  import ate_pkg::*;
(
  input wire logic [9:0] instrWord,
  output ate_kind_type kind
);

  function automatic ate_kind_type decodeKind(input logic [9:0] w);
    ate_kind_type k;
    k = ATE_K_NONE;
    unique case (w)
      `ATE_OP_LCD1: k = ATE_K_LCD1;
      `ATE_OP_LCD2: k = ATE_K_LCD2;
      `ATE_OP_LCD3: k = ATE_K_LCD3;
      `ATE_OP_DREG: k = ATE_K_DREG;
      `ATE_OP_EREG: k = ATE_K_EREG;
      `ATE_OP_FR0: k = ATE_K_FR0;
      default: k = ATE_K_NONE;
    endcase
    return k;
  endfunction : decodeKind

  assign kind = decodeKind(instrWord);

endmodule : ate_decode

`default_nettype wire

// [design/ate_ahb_slave.sv]
// ahb-lite address phase capture, zero wait states
`default_nettype none
`include "ate_params.svh"

module ate_ahb_slave
  import ate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wrStrobe,
  output logic rdActive,
  output logic [7:0] phaseAddr
);

  ate_bus_state_type st_r;
  ate_bus_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.dataPhase = 1'b0;
    // only whole-word nonseq transfers are taken; others are ignored
    if (hsel && hready && htrans == `ATE_HTRANS_NONSEQ && hsize == `ATE_HSIZE_WORD) begin
      st_nxt.dataPhase = 1'b1;
      st_nxt.write = hwrite;
      st_nxt.addr = {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wrStrobe = st_r.dataPhase & st_r.write;
  assign rdActive = st_r.dataPhase & ~st_r.write;
  assign phaseAddr = st_r.addr;

endmodule : ate_ahb_slave

`default_nettype wire

// [design/ate_transfer_exec.sv]
// execution of accumulator transfer instructions with ahb-lite register access
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`default_nettype none
`include "ate_params.svh"

// Behaviour
// - first lcd control register takes accumulator, one cycle
// - code 1010101001 loads second lcd control
// - third lcd control register takes accumulator, one cycle
// - d register takes accumulator bits two..zero
// - e gets b high, accumulator low
// - code 1000101000 loads port structure control zero
module ate_transfer_exec
  import ate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic execValid,
  input wire logic [9:0] execWord,
  input wire logic [3:0] accIn,
  input wire logic [3:0] regBIn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [3:0] lcdCtrlFirst,
  output logic [3:0] lcdCtrlSecond,
  output logic [3:0] lcdCtrlThird,
  output logic [2:0] dReg,
  output logic [7:0] eReg,
  output logic [3:0] portStructCtrl0,
  output logic skipNext
);

  ate_core_state_type st_r;
  ate_core_state_type st_nxt;
  logic wrStrobe;
  logic rdActive;
  logic [7:0] phaseAddr;
  logic busIssue;
  logic issue;
  logic [9:0] issueWord;
  logic [3:0] srcAcc;
  logic [3:0] srcB;
  ate_kind_type kind;

  ate_ahb_slave u_bus (
    .clock(clock),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wrStrobe(wrStrobe),
    .rdActive(rdActive),
    .phaseAddr(phaseAddr)
  );

  // bus issue wins over the core port in the same cycle
  assign busIssue = wrStrobe && phaseAddr == `ATE_ADR_INSTR;
  assign issue = busIssue | execValid;
  assign issueWord = busIssue ? hwdata[9:0] : execWord;
  assign srcAcc = busIssue ? st_r.acc : accIn;
  assign srcB = busIssue ? st_r.regB : regBIn;

  ate_decode u_dec (
    .instrWord(issueWord),
    .kind(kind)
  );

  always_comb begin
    st_nxt = st_r;
    // source registers change only by bus writes, never by execution
    if (wrStrobe && phaseAddr == `ATE_ADR_ACC) begin
      st_nxt.acc = hwdata[3:0];
    end
    if (wrStrobe && phaseAddr == `ATE_ADR_REGB) begin
      st_nxt.regB = hwdata[3:0];
    end
    if (issue) begin
      st_nxt.lastWord = issueWord;
      st_nxt.lastKind = kind;
      if (kind != ATE_K_NONE) begin
        st_nxt.execCount = st_r.execCount + 16'h0001;
      end
      unique case (kind)
        ATE_K_LCD1: st_nxt.lcdCtrlFirst = srcAcc;
        ATE_K_LCD2: st_nxt.lcdCtrlSecond = srcAcc;
        ATE_K_LCD3: st_nxt.lcdCtrlThird = srcAcc;
        ATE_K_DREG: st_nxt.dReg = srcAcc[`ATE_D_MSB:0];
        ATE_K_EREG: begin
          st_nxt.eReg[`ATE_E_HI_MSB:`ATE_E_HI_LSB] = srcB;
          st_nxt.eReg[`ATE_E_LO_MSB:0] = srcAcc;
        end
        ATE_K_FR0: st_nxt.portStructCtrl0 = srcAcc;
        ATE_K_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r.acc <= `ATE_RST_NIBBLE;
      st_r.regB <= `ATE_RST_NIBBLE;
      st_r.lastWord <= `ATE_RST_WORD;
      st_r.lcdCtrlFirst <= `ATE_RST_NIBBLE;
      st_r.lcdCtrlSecond <= `ATE_RST_NIBBLE;
      st_r.lcdCtrlThird <= `ATE_RST_NIBBLE;
      st_r.dReg <= `ATE_RST_D;
      st_r.eReg <= `ATE_RST_E;
      st_r.portStructCtrl0 <= `ATE_RST_NIBBLE;
      st_r.lastKind <= ATE_K_NONE;
      st_r.execCount <= `ATE_RST_COUNT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // read mux over registered state; unmapped reads return zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rdActive) begin
      unique case (phaseAddr)
        `ATE_ADR_ACC: hrdata = {28'h000_0000, st_r.acc};
        `ATE_ADR_REGB: hrdata = {28'h000_0000, st_r.regB};
        `ATE_ADR_INSTR: hrdata = {22'h00_0000, st_r.lastWord};
        `ATE_ADR_LCD1: hrdata = {28'h000_0000, st_r.lcdCtrlFirst};
        `ATE_ADR_LCD2: hrdata = {28'h000_0000, st_r.lcdCtrlSecond};
        `ATE_ADR_LCD3: hrdata = {28'h000_0000, st_r.lcdCtrlThird};
        `ATE_ADR_DREG: hrdata = {29'h0000_0000, st_r.dReg};
        `ATE_ADR_EREG: hrdata = {24'h00_0000, st_r.eReg};
        `ATE_ADR_FR0: hrdata = {28'h000_0000, st_r.portStructCtrl0};
        `ATE_ADR_STATUS: hrdata = {29'h0000_0000, st_r.lastKind};
        `ATE_ADR_COUNT: hrdata = {16'h0000, st_r.execCount};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign lcdCtrlFirst = st_r.lcdCtrlFirst;
  assign lcdCtrlSecond = st_r.lcdCtrlSecond;
  assign lcdCtrlThird = st_r.lcdCtrlThird;
  assign dReg = st_r.dReg;
  assign eReg = st_r.eReg;
  assign portStructCtrl0 = st_r.portStructCtrl0;
  assign skipNext = 1'b0;

endmodule : ate_transfer_exec

`default_nettype wire

// [verif/ate_transfer_exec_checker.sv]
// assertions for the accumulator transfer block
`default_nettype none
module ate_transfer_exec_checker
  import ate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic execValid,
  input wire logic [9:0] execWord,
  input wire logic [3:0] accIn,
  input wire logic [3:0] regBIn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [3:0] lcdCtrlFirst,
  input wire logic [3:0] lcdCtrlSecond,
  input wire logic [3:0] lcdCtrlThird,
  input wire logic [2:0] dReg,
  input wire logic [7:0] eReg,
  input wire logic [3:0] portStructCtrl0,
  input wire logic skipNext
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busIns_r;
  logic [3:0] acc_r;
  logic [3:0] regB_r;
  logic go;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // bus write to the instruction offset is in its data phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busIns_r <= 1'b0;
      acc_r <= 4'h0;
      regB_r <= 4'h0;
    end else begin
      busIns_r <= hsel && hready && htrans == 2'b10 && hwrite && hsize == 3'b010
        && haddr[7:0] == 8'h08;
      acc_r <= accIn;
      regB_r <= regBIn;
    end
  end
  assign go = execValid && !busIns_r;
  a_lcd_first_load: assert property (go && execWord == 10'h2a8 |=> lcdCtrlFirst == acc_r)
    else $error("first lcd control not loaded");
  a_lcd_second_load: assert property (go && execWord == 10'h2a9 |=> lcdCtrlSecond == acc_r)
    else $error("second lcd control not loaded");
  a_lcd_third_load: assert property (go && execWord == 10'h2aa |=> lcdCtrlThird == acc_r)
    else $error("third lcd control not loaded");
  a_dreg_low_bits: assert property (go && execWord == 10'h029 |=> dReg == acc_r[2:0])
    else $error("d register wrong");
  a_ereg_split: assert property (go && execWord == 10'h01a |=> eReg == {regB_r, acc_r})
    else $error("e register wrong");
  a_struct_ctrl_load: assert property (go && execWord == 10'h228
    |=> portStructCtrl0 == acc_r)
    else $error("port structure control not loaded");
  a_idle_hold: assert property (!execValid && !busIns_r
    |=> $stable({lcdCtrlFirst, lcdCtrlSecond, lcdCtrlThird, dReg, eReg, portStructCtrl0}))
    else $error("destination changed while idle");
  a_never_skip: assert property (go |=> skipNext == 1'b0)
    else $error("skip raised");
endmodule : ate_transfer_exec_checker
bind ate_transfer_exec ate_transfer_exec_checker chk (
  .clock(clock),
  .rst_b(rst_b),
  .execValid(execValid),
  .execWord(execWord),
  .accIn(accIn),
  .regBIn(regBIn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hready(hready),
  .lcdCtrlFirst(lcdCtrlFirst),
  .lcdCtrlSecond(lcdCtrlSecond),
  .lcdCtrlThird(lcdCtrlThird),
  .dReg(dReg),
  .eReg(eReg),
  .portStructCtrl0(portStructCtrl0),
  .skipNext(skipNext)
);
`default_nettype wire

// [verif/ate_transfer_exec_test.sv]
// self-checking testbench for the accumulator transfer block
`default_nettype none
module ate_transfer_exec_test;
  import ate_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_b, execValid, hsel, hwrite, hready, hreadyout, hresp, skipNext;
  logic [9:0] execWord;
  logic [3:0] accIn, regBIn, lcdCtrlFirst, lcdCtrlSecond, lcdCtrlThird, portStructCtrl0;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, dReg;
  logic [7:0] eReg;
  logic [7:0] e [6];
  logic [9:0] ops [6] = '{10'h2a8, 10'h2a9, 10'h2aa, 10'h029, 10'h01a, 10'h228};
  int n_fail = 0;
  int cmp_count = 0;
  assign hready = hreadyout;
  ate_transfer_exec dut (
    .clock(clock),
    .rst_b(rst_b),
    .execValid(execValid),
    .execWord(execWord),
    .accIn(accIn),
    .regBIn(regBIn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .lcdCtrlFirst(lcdCtrlFirst),
    .lcdCtrlSecond(lcdCtrlSecond),
    .lcdCtrlThird(lcdCtrlThird),
    .dReg(dReg),
    .eReg(eReg),
    .portStructCtrl0(portStructCtrl0),
    .skipNext(skipNext)
  );
  always #12.5 clock = ~clock;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic exec(input logic [9:0] w, input logic [3:0] a, input logic [3:0] b);
    @(posedge clock);
    execValid <= 1'b1;
    execWord <= w;
    accIn <= a;
    regBIn <= b;
    @(posedge clock);
    execValid <= 1'b0;
    @(negedge clock);
  endtask : exec
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  function automatic logic [31:0] pk();
    return {5'h0, e[0][3:0], e[1][3:0], e[2][3:0], e[3][2:0], e[4], e[5][3:0]};
  endfunction : pk
  function automatic logic [31:0] outs();
    return {5'h0, lcdCtrlFirst, lcdCtrlSecond, lcdCtrlThird, dReg, eReg, portStructCtrl0};
  endfunction : outs
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (2000) @(posedge clock);
    n_fail++;
    finish_test();
  end
  initial begin
    {clock, rst_b, execValid, execWord, accIn, regBIn, hwrite, htrans, haddr, hwdata} = '0;
    hsel = 1'b1;
    hsize = 3'b010;
    foreach (e[i]) e[i] = 8'h00;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    check("reset", outs(), 32'h0000_0000);
    check("reset bus", {29'h0, skipNext, hresp, hreadyout}, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      exec(ops[i], 4'(i + 10), 4'h3);
      e[i] = (i == 3) ? {5'h0, 3'(i + 10)} : (i == 4) ? {4'h3, 4'(i + 10)} : 8'(i + 10);
      check("core", outs(), pk());
    end
    exec(10'h000, 4'h1, 4'h2);
    check("unknown", outs(), pk());
    check("skip", {31'h0, skipNext}, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0009);
    bus(1'b1, 8'h04, 32'h0000_0006);
    bus(1'b1, 8'h08, 32'h0000_0228);
    bus(1'b1, 8'h0c, 32'h0000_0000);
    bus(1'b0, 8'h20, 32'h0000_0000);
    check("bus fr0", q, 32'h0000_0009);
    bus(1'b0, 8'h0c, 32'h0000_0000);
    check("lcd1 ro", q, 32'h0000_000a);
    bus(1'b0, 8'h00, 32'h0000_0000);
    check("acc kept", q, 32'h0000_0009);
    bus(1'b0, 8'h3c, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    @(posedge clock);
    rst_b <= 1'b0;
    @(negedge clock);
    check("mid reset", outs(), 32'h0000_0000);
    @(posedge clock);
    rst_b <= 1'b1;
    exec(ops[0], 4'h7, 4'h2);
    check("after reset", outs(), 32'h0380_0000);
    finish_test();
  end
endmodule : ate_transfer_exec_test
`default_nettype wire
